// *** fopc_pkg.sv ***
// Package of opcodes, register layout and timing constants for the flash command group.
package fopc_pkg;
   // Command opcodes.
   localparam logic [7:0] OP_QUAD_PROG    = 8'h38;
   localparam logic [7:0] OP_PAGE_PROG    = 8'h02;
   localparam logic [7:0] OP_WRITE_ENABLE_CMD         = 8'h06;
   localparam logic [7:0] OP_DEEP_SLEEP   = 8'hB9;
   localparam logic [7:0] OP_WAKE         = 8'hAB;
   localparam logic [7:0] OP_ENTER_OTP    = 8'hB1;
   localparam logic [7:0] OP_EXIT_OTP     = 8'hC1;
   localparam logic [7:0] OP_READ_SEC     = 8'h2B;
   localparam logic [7:0] OP_WRITE_SEC    = 8'h2F;
   localparam logic [7:0] OP_PROT_SELECT  = 8'h68;
   localparam logic [7:0] OP_CHIP_UNLOCK  = 8'h98;
   localparam logic [7:0] OP_RST_ENABLE   = 8'h66;
   localparam logic [7:0] OP_RESET        = 8'h99;
   // Security register field positions.
   localparam int SEC_PROT_SEL  = 7;
   localparam int SEC_ERASE_FL  = 6;
   localparam int SEC_PROG_FL   = 5;
   localparam int SEC_RSVD      = 4;
   localparam int SEC_ERASE_SUS = 3;
   localparam int SEC_PROG_SUS  = 2;
   localparam int SEC_OTP_LOCK  = 1;
   localparam int SEC_FACT_LOCK = 0;
   // Address and page geometry.
   localparam int ADDR_BITS     = 24;
   localparam int PAGE_BITS     = 8;
   localparam logic [ADDR_BITS-1:0] OTP_TOP = 24'h0001FF;
   // Timing: clock 25 MHz.
   localparam int CLK_MHZ              = 25;
   localparam int SLEEP_ENTRY_DELAY_NS = 3000;
   localparam int SLEEP_ENTRY_CYC      =
      (SLEEP_ENTRY_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int PROG_CYCLE_TIME_US   = 10;
   localparam int PROG_CYCLE_CYC       = PROG_CYCLE_TIME_US * CLK_MHZ;
   // Phase encoding of the serial frame.
   typedef enum logic [4:0] {
      FP_OPCODE = 5'b00001,
      FP_ADDR   = 5'b00010,
      FP_DATA   = 5'b00100,
      FP_OUT    = 5'b01000,
      FP_IGNORE = 5'b10000
   } fopc_phase_t;
endpackage : fopc_pkg

// *** fopc_sync.sv ***
// Two flip-flop synchroniser for the link pins.
`timescale 1ns/1ps
`default_nettype none
module fopc_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,   // System clock.
   input  wire logic         i_reset, // Synchronous reset.
   input  wire logic [W-1:0] i_d,     // Asynchronous input.
   output logic      [W-1:0] o_q      // Synchronised output.
);
   logic [W-1:0] stage1;
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         stage1 <= '0;
         o_q    <= '0;
      end else begin
         stage1 <= i_d;
         o_q    <= stage1;
      end
   end
endmodule : fopc_sync
`default_nettype wire

// *** fopc_core.sv ***
// Command interpreter for quad program, deep sleep, OTP area and security register.
`timescale 1ns/1ps
`default_nettype none
module fopc_core (
   input  wire logic       i_clk,           // System clock, 25 MHz.
   input  wire logic       i_reset,         // Synchronous reset, active high.
   input  wire logic       i_cs_n,          // Chip select pin, active low.
   input  wire logic       i_sclk,          // Serial clock pin.
   input  wire logic [3:0] i_sio,           // Four data lines in.
   output logic      [3:0] o_sio,           // Four data lines out.
   output logic      [3:0] o_sio_oe,        // Output enables per data line.
   input  wire logic       i_quad_mode,     // Four-line command mode active.
   input  wire logic       i_quad_enable,   // Quad-enable status bit.
   input  wire logic       i_range_protect, // Range protection covers the address.
   input  wire logic       i_factory_lock,  // Factory lock strap, sampled every clock outside reset.
   input  wire logic       i_prog_fail,     // Array program failure pulse.
   input  wire logic       i_erase_done,    // Erase finished pulse.
   input  wire logic       i_erase_fail,    // Erase failed or protected pulse.
   input  wire logic       i_erase_susp,    // Erase suspended pulse.
   input  wire logic       i_erase_resume,  // Erase resumed pulse.
   input  wire logic       i_prog_susp,     // Program suspended pulse.
   input  wire logic       i_prog_resume,   // Program resumed pulse.
   input  wire logic       i_block_unlock,  // Unlock command from block-lock logic.
   output logic            o_wel,           // Write-enable latch.
   output logic            o_wip,           // Write in progress.
   output logic            o_asleep,        // Deep sleep state.
   output logic            o_otp_sel,       // OTP area selected.
   output logic            o_blocks_locked, // All blocks locked in block mode.
   output logic [7:0]      o_sec_reg,       // Security register image.
   output logic            o_wr_en,         // Array byte write strobe.
   output logic [23:0]     o_wr_addr,       // Array byte write address.
   output logic [7:0]      o_wr_data        // Array byte write data.
);
   import fopc_pkg::*;

   logic [5:0]  sync_q;
   logic        cs_n_s, sclk_s, sclk_d, cs_d;
   logic [3:0]  sio_s;
   // Chip select crosses in its active sense, so a cleared synchroniser reads as deselected.
   fopc_sync #(.W(6)) u_sync (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_d     ({~i_cs_n, i_sclk, i_sio}),
      .o_q     (sync_q)
   );
   assign cs_n_s = ~sync_q[5];
   assign sclk_s = sync_q[4];
   assign sio_s  = sync_q[3:0];

   wire sclk_rise = ~cs_n_s & sclk_s & ~sclk_d;
   wire sclk_fall = ~cs_n_s & ~sclk_s & sclk_d;
   wire cs_rise   = cs_n_s & ~cs_d;

   fopc_phase_t phase;
   logic [7:0]  shreg;
   logic [5:0]  bitcnt;
   logic [7:0]  opcode;
   logic [23:0] addr;
   logic        quad_io;
   logic        byte_aligned;
   logic        data_seen;
   logic        rst_armed;
   logic [2:0]  out_idx;
   logic        prot_sel, otp_lock, fact_lock;
   logic        erase_fl, prog_fl, erase_sus, prog_sus;
   logic [15:0] prog_cnt;
   logic [7:0]  sleep_cnt;
   logic        sleep_pend;
   logic        prog_ok;

   wire [2:0] step     = quad_io ? 3'd4 : 3'd1;
   wire [7:0] next_sh  = quad_io ? {shreg[3:0], sio_s} : {shreg[6:0], sio_s[0]};
   wire [5:0] next_cnt = bitcnt + {3'd0, step};
   wire       byte_end = next_cnt[2:0] == 3'd0;

   wire op_allowed = ~o_asleep | (next_sh == OP_WAKE) | (next_sh == OP_RST_ENABLE)
                   | (next_sh == OP_RESET);
   wire quad_ok = o_wel & i_quad_enable & ~i_quad_mode & ~o_wip;
   wire region_prot = prot_sel ? o_blocks_locked : i_range_protect;
   wire otp_ok  = ~otp_lock & (addr <= OTP_TOP);
   wire frame_ok = byte_aligned & data_seen;

   // Register image with reserved bit at zero.
   wire [7:0] sec_img = {prot_sel, erase_fl, prog_fl, 1'b0,
                         erase_sus, prog_sus, otp_lock, fact_lock};

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sclk_d <= 1'b0;
         cs_d   <= 1'b1;
      end else begin
         sclk_d <= sclk_s;
         cs_d   <= cs_n_s;
      end
   end

   // Frame decoder.
   always_ff @(posedge i_clk) begin
      if (i_reset || cs_n_s) begin
         phase        <= FP_OPCODE;
         bitcnt       <= '0;
         shreg        <= '0;
         quad_io      <= i_reset ? 1'b0 : i_quad_mode;
         byte_aligned <= 1'b1;
         data_seen    <= 1'b0;
         if (i_reset) begin
            opcode <= '0;
            addr   <= '0;
         end
      end else if (sclk_rise) begin
         bitcnt       <= next_cnt;
         shreg        <= next_sh;
         byte_aligned <= byte_end;
         case (phase)
            FP_OPCODE: begin
               if (byte_end) begin
                  bitcnt <= '0;
                  opcode <= op_allowed ? next_sh : 8'h00;
                  // Quad program switches lanes to four.
                  if (!op_allowed) begin
                     phase <= FP_IGNORE;
                  end else if (next_sh == OP_QUAD_PROG) begin
                     phase   <= quad_ok ? FP_ADDR : FP_IGNORE;
                     quad_io <= 1'b1;
                  end else if (next_sh == OP_PAGE_PROG) begin
                     phase <= (o_wel & ~o_wip) ? FP_ADDR : FP_IGNORE;
                  end else if (next_sh == OP_READ_SEC) begin
                     phase <= FP_OUT;
                  end else begin
                     phase <= FP_DATA;
                  end
               end
            end
            FP_ADDR: begin
               if (next_cnt == 6'd24) begin
                  bitcnt <= '0;
                  phase  <= FP_DATA;
                  addr   <= {addr[15:0], next_sh};
               end else if (byte_end) begin
                  addr <= {addr[15:0], next_sh};
               end
            end
            FP_DATA: begin
               if (byte_end) begin
                  data_seen <= 1'b1;
                  bitcnt    <= '0;
                  // Low address byte wraps inside the page.
                  addr[PAGE_BITS-1:0] <= addr[PAGE_BITS-1:0] + 8'h01;
               end
            end
            FP_OUT: begin
            end
            FP_IGNORE: begin
            end
            default: phase <= FP_IGNORE;
         endcase
      end
   end

   // Array write strobes during program data.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_wr_en   <= 1'b0;
         o_wr_addr <= '0;
         o_wr_data <= '0;
      end else begin
         o_wr_en <= 1'b0;
         if (sclk_rise && phase == FP_DATA && byte_end && !region_prot
             && (opcode == OP_QUAD_PROG || opcode == OP_PAGE_PROG)
             && (!o_otp_sel || otp_ok)) begin
            // Same write path as single-line program.
            o_wr_en   <= 1'b1;
            o_wr_addr <= addr;
            o_wr_data <= next_sh;
         end
      end
   end

   // Security byte shifted out, repeating each byte.
   always_ff @(posedge i_clk) begin
      if (i_reset || cs_n_s) begin
         o_sio    <= '0;
         o_sio_oe <= '0;
         out_idx  <= 3'd7;
      end else if (sclk_fall && phase == FP_OUT) begin
         if (quad_io) begin
            o_sio    <= out_idx[2] ? sec_img[7:4] : sec_img[3:0];
            o_sio_oe <= 4'hF;
            out_idx  <= out_idx - 3'd4;
         end else begin
            o_sio    <= {2'b00, sec_img[out_idx], 1'b0};
            o_sio_oe <= 4'b0010;
            out_idx  <= out_idx - 3'd1;
         end
      end
   end

   // Command completion at chip select rise.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_wel          <= 1'b0;
         o_wip          <= 1'b0;
         o_asleep       <= 1'b0;
         o_otp_sel      <= 1'b0;
         prot_sel       <= 1'b0;
         otp_lock       <= 1'b0;
         prog_cnt       <= '0;
         sleep_cnt      <= '0;
         sleep_pend     <= 1'b0;
         rst_armed      <= 1'b0;
         prog_ok        <= 1'b0;
      end else begin
         if (sleep_pend) begin
            if (sleep_cnt == 8'(SLEEP_ENTRY_CYC - 1)) begin
               o_asleep   <= 1'b1;
               sleep_pend <= 1'b0;
            end
            sleep_cnt <= sleep_cnt + 8'h01;
         end
         if (o_wip) begin
            if (prog_cnt == 16'(PROG_CYCLE_CYC - 1)) begin
               o_wip <= 1'b0;
               o_wel <= 1'b0;
            end
            prog_cnt <= prog_cnt + 16'h0001;
         end
         if (cs_rise && phase == FP_DATA) begin
            rst_armed <= 1'b0;
            case (opcode)
               OP_WRITE_ENABLE_CMD:        if (byte_aligned && bitcnt == 0 && !data_seen) o_wel <= 1'b1;
               OP_DEEP_SLEEP:  if (!data_seen && bitcnt == 0) begin
                  sleep_pend <= 1'b1;
                  sleep_cnt  <= '0;
               end
               OP_WAKE:        if (!data_seen && bitcnt == 0) o_asleep <= 1'b0;
               // OTP area select on exact edge.
               OP_ENTER_OTP:   if (!data_seen && bitcnt == 0) o_otp_sel <= 1'b1;
               OP_EXIT_OTP:    if (!data_seen && bitcnt == 0) o_otp_sel <= 1'b0;
               OP_RST_ENABLE:  rst_armed <= !data_seen && bitcnt == 0;
               OP_RESET:       if (rst_armed && !data_seen && bitcnt == 0) begin
                  o_asleep   <= 1'b0;
                  sleep_pend <= 1'b0;
                  o_otp_sel  <= 1'b0;
                  o_wel      <= 1'b0;
               end
               // Lock bit only, aligned, outside OTP.
               OP_WRITE_SEC:   if (o_wel && !o_wip && byte_aligned && !o_otp_sel) begin
                  otp_lock <= 1'b1;
                  o_wel    <= 1'b0;
               end
               OP_PROT_SELECT: if (o_wel && !o_wip && byte_aligned && !data_seen) begin
                  prot_sel <= 1'b1;
                  o_wel    <= 1'b0;
               end
               OP_PAGE_PROG, OP_QUAD_PROG: if (frame_ok) begin
                  // Cycle starts at chip select rise.
                  o_wip    <= 1'b1;
                  prog_cnt <= '0;
                  prog_ok  <= !region_prot && (!o_otp_sel || otp_ok);
               end
               default: ;
            endcase
         end
      end
   end

   // Volatile flags and strap capture.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         erase_fl        <= 1'b0;
         prog_fl         <= 1'b0;
         erase_sus       <= 1'b0;
         prog_sus        <= 1'b0;
         fact_lock       <= 1'b0;
         o_blocks_locked <= 1'b1;
         o_sec_reg       <= '0;
      end else begin
         fact_lock <= i_factory_lock;
         o_sec_reg <= sec_img;
         if (i_block_unlock) o_blocks_locked <= 1'b0;
         // Program fail by result of last program.
         if (o_wip && prog_cnt == 16'(PROG_CYCLE_CYC - 1)) prog_fl <= ~prog_ok;
         if (i_prog_fail) prog_fl <= 1'b1;
         if (i_erase_done) erase_fl <= i_erase_fail;
         if (i_erase_resume) erase_sus <= 1'b0;
         if (i_erase_susp) erase_sus <= 1'b1;
         if (i_prog_resume) prog_sus <= 1'b0;
         if (i_prog_susp) prog_sus <= 1'b1;
      end
   end
endmodule : fopc_core
`default_nettype wire

// *** fopc_core_asserts.sv ***
// Port-level assertions for the flash command group core.
`timescale 1ns/1ps
`default_nettype none
module fopc_core_asserts
   import fopc_pkg::*;
(
   input wire logic       i_clk,     // System clock.
   input wire logic       i_reset,   // Synchronous reset.
   input wire logic       i_cs_n,    // Chip select pin.
   input wire logic [3:0] o_sio_oe,  // Data line enables.
   input wire logic       o_wel,     // Write-enable latch.
   input wire logic       o_wip,     // Write in progress.
   input wire logic       o_asleep,  // Deep sleep state.
   input wire logic       o_otp_sel, // OTP area selected.
   input wire logic [7:0] o_sec_reg, // Security register image.
   input wire logic       o_wr_en    // Array write strobe.
);
   logic [9:0] wip_cnt;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);
   // Counts how long the busy flag has stood.
   always_ff @(posedge i_clk) begin
      if (i_reset || !o_wip) begin
         wip_cnt <= 10'h000;
      end else begin
         wip_cnt <= wip_cnt + 10'h001;
      end
   end
   resv_zero_a: assert property (o_sec_reg[SEC_RSVD] == 1'b0)
      else $error("reserved security bit not zero");
   lock_sticky_a: assert property (o_sec_reg[SEC_OTP_LOCK] |=> o_sec_reg[SEC_OTP_LOCK])
      else $error("OTP lock bit cleared");
   prot_sticky_a: assert property (o_sec_reg[SEC_PROT_SEL] |=> o_sec_reg[SEC_PROT_SEL])
      else $error("protection select bit cleared");
   otp_nolock_a: assert property (o_otp_sel |=> !$rose(o_sec_reg[SEC_OTP_LOCK]))
      else $error("security write taken in OTP area");
   sleep_hold_a: assert property ((o_asleep && i_cs_n) [*8] |=> o_asleep)
      else $error("sleep left without command");
   sleep_nowel_a: assert property (o_asleep |=> !$rose(o_wel))
      else $error("write enable taken while asleep");
   sleep_delay_a: assert property ($rose(o_asleep) |-> $past(i_cs_n, 70))
      else $error("sleep entered too early");
   wip_time_a: assert property ($fell(o_wip) |->
      (wip_cnt >= PROG_CYCLE_CYC - 2) && (wip_cnt <= PROG_CYCLE_CYC + 2))
      else $error("program cycle length wrong");
   wel_clear_a: assert property ($fell(o_wip) |-> ##[0:2] !o_wel)
      else $error("latch not cleared after cycle");
   wr_gate_a: assert property (o_wr_en |-> o_wel && !o_asleep)
      else $error("array write without latch");
   oe_idle_a: assert property (i_cs_n [*8] |-> o_sio_oe == 4'h0)
      else $error("data lines driven while deselected");
endmodule : fopc_core_asserts
bind fopc_core fopc_core_asserts u_chk (.i_clk, .i_reset, .i_cs_n, .o_sio_oe, .o_wel,
   .o_wip, .o_asleep, .o_otp_sel, .o_sec_reg, .o_wr_en);
`default_nettype wire

// *** fopc_host_model.sv ***
// Host serial controller model: chip select, serial clock and data lines.
`timescale 1ns/1ps
`default_nettype none
module fopc_host_model (
   input  wire logic       i_clk,  // System clock for pacing.
   input  wire logic [3:0] i_sio,  // Data lines from the device.
   output logic            o_cs_n, // Chip select, active low.
   output logic            o_sclk, // Serial clock, still between frames.
   output logic      [3:0] o_sio   // Data lines to the device.
);
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_sio  = 4'h5;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask : tick
   // One serial clock of eight system clocks; data set while low.
   task automatic clk1(input logic [3:0] v);
      o_sio <= v;
      tick(4);
      o_sclk <= 1'b1;
      tick(4);
      o_sclk <= 1'b0;
   endtask : clk1
   task automatic begin_frame();
      o_cs_n <= 1'b0;
      tick(4);
   endtask : begin_frame
   // Released lines show the inverse of the last value.
   task automatic end_frame();
      o_cs_n <= 1'b1;
      o_sio  <= ~o_sio;
      tick(16);
   endtask : end_frame
   // MSB first, upper lines toggled in single-line mode.
   task automatic send(input logic [7:0] b, input logic q);
      if (q) begin
         clk1(b[7:4]);
         clk1(b[3:0]);
      end else begin
         for (int i = 7; i >= 0; i--) clk1({{3{~b[i]}}, b[i]});
      end
   endtask : send
   task automatic rd(output logic [7:0] v);
      for (int i = 7; i >= 0; i--) begin
         tick(4);
         o_sclk <= 1'b1;
         tick(3);
         v[i] = i_sio[1];
         tick(1);
         o_sclk <= 1'b0;
      end
   endtask : rd
   // Single-opcode frame; odd adds one stray bit before chip select rises.
   task automatic cmd(input logic [7:0] op, input logic q, input logic odd);
      begin_frame();
      send(op, q);
      if (odd) clk1(4'h0);
      end_frame();
   endtask : cmd
endmodule : fopc_host_model
`default_nettype wire

// *** test_flash_otp_protect_power_cmds.sv ***
// Self-checking bench for the flash command group core.
`timescale 1ns/1ps
`default_nettype none
module test_flash_otp_protect_power_cmds;
   import fopc_pkg::*;
   logic        clk, rst, quad_mode, quad_en, erase_fail, cs_n, sclk, range_prot, fact_strap;
   logic [6:0]  ev;
   logic [3:0]  sio_in, sio_out, sio_oe;
   logic        write_enable_latch, write_in_progress_flag, asleep, otp_sel, blk_lock, wr_en;
   logic [7:0]  sec, wr_data;
   logic [23:0] wr_addr;
   logic [31:0] wq[$];
   int          bad_count, checked;
   fopc_host_model u_host (.i_clk(clk), .i_sio(sio_out), .o_cs_n(cs_n), .o_sclk(sclk),
      .o_sio(sio_in));
   fopc_core u_dut (.i_clk(clk), .i_reset(rst), .i_cs_n(cs_n), .i_sclk(sclk),
      .i_sio(sio_in), .o_sio(sio_out), .o_sio_oe(sio_oe), .i_quad_mode(quad_mode),
      .i_quad_enable(quad_en), .i_range_protect(range_prot), .i_factory_lock(fact_strap),
      .i_prog_fail(ev[0]), .i_erase_done(ev[1]), .i_erase_fail(erase_fail),
      .i_erase_susp(ev[2]), .i_erase_resume(ev[3]), .i_prog_susp(ev[4]),
      .i_prog_resume(ev[5]), .i_block_unlock(ev[6]), .o_wel(write_enable_latch), .o_wip(write_in_progress_flag),
      .o_asleep(asleep), .o_otp_sel(otp_sel), .o_blocks_locked(blk_lock),
      .o_sec_reg(sec), .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) if (wr_en === 1'b1) wq.push_back({wr_addr, wr_data});
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic stop_test();
      $display("checked %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task automatic pulse(input logic [6:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 7'h00;
      u_host.tick(6);
   endtask : pulse
   task automatic reset_dut();
      rst <= 1'b1;
      u_host.tick(16);
      rst <= 1'b0;
      u_host.tick(4);
   endtask : reset_dut
   task automatic wait_wip();
      for (int i = 0; i < 400 && write_in_progress_flag !== 1'b0; i++) @(posedge clk);
      u_host.tick(2);
      chk(write_in_progress_flag, 1'b0);
   endtask : wait_wip
   // Quad program of bytes A5, 3C: opcode, six address nibbles, data nibbles.
   task automatic qprog(input logic [23:0] a, input logic q);
      logic [39:0] w;
      w = {a, 16'hA53C};
      u_host.begin_frame();
      u_host.send(OP_QUAD_PROG, q);
      for (int i = 9; i >= 0; i--) u_host.clk1(w[i*4+:4]);
      u_host.end_frame();
   endtask : qprog
   task automatic t_flags();
      logic [7:0] a, b;
      chk(sec, 8'h01);
      chk(blk_lock, 1'b1);
      pulse(7'h40);
      chk(blk_lock, 1'b0);
      erase_fail <= 1'b1;
      pulse(7'h16);
      u_host.begin_frame();
      u_host.send(OP_READ_SEC, 1'b0);
      u_host.rd(a);
      u_host.rd(b);
      chk(sio_oe, 4'h2);
      u_host.end_frame();
      chk(a, 8'h4D);
      chk(b, 8'h4D);
      erase_fail <= 1'b0;
      pulse(7'h2B);
      chk(sec, 8'h21);
      $display("flags test done");
   endtask : t_flags
   task automatic t_qprog();
      quad_en <= 1'b1;
      qprog(24'h0012FF, 1'b0);
      wait_wip();
      chk(wq.size(), 0);
      u_host.cmd(OP_WRITE_ENABLE_CMD, 1'b0, 1'b0);
      chk(write_enable_latch, 1'b1);
      qprog(24'h0012FF, 1'b0);
      chk(write_in_progress_flag, 1'b1);
      wait_wip();
      chk(write_enable_latch, 1'b0);
      chk(wq.size(), 2);
      chk(wq[0], 32'h0012FFA5);
      chk(wq[1], 32'h0012003C);
      chk(sec[SEC_PROG_FL], 1'b0);
      wq.delete();
      u_host.cmd(OP_WRITE_ENABLE_CMD, 1'b0, 1'b0);
      u_host.begin_frame();
      u_host.send(OP_PAGE_PROG, 1'b0);
      u_host.send(8'h00, 1'b0);
      u_host.send(8'h20, 1'b0);
      u_host.send(8'h07, 1'b0);
      u_host.send(8'h96, 1'b0);
      u_host.end_frame();
      wait_wip();
      chk(wq.size(), 1);
      chk(wq[0], 32'h00200796);
      wq.delete();
      range_prot <= 1'b1;
      u_host.cmd(OP_WRITE_ENABLE_CMD, 1'b0, 1'b0);
      qprog(24'h0012FF, 1'b0);
      wait_wip();
      chk(wq.size(), 0);
      chk(sec[SEC_PROG_FL], 1'b1);
      range_prot <= 1'b0;
      $display("quad program test done");
   endtask : t_qprog
   task automatic t_sleep();
      u_host.cmd(OP_DEEP_SLEEP, 1'b0, 1'b1);
      u_host.tick(100);
      chk(asleep, 1'b0);
      u_host.cmd(OP_DEEP_SLEEP, 1'b0, 1'b0);
      chk(asleep, 1'b0);
      u_host.tick(100);
      chk(asleep, 1'b1);
      u_host.cmd(OP_WRITE_ENABLE_CMD, 1'b0, 1'b0);
      chk(write_enable_latch, 1'b0);
      u_host.tick(100);
      chk(asleep, 1'b1);
      u_host.cmd(OP_RST_ENABLE, 1'b0, 1'b0);
      u_host.cmd(OP_RESET, 1'b0, 1'b0);
      chk(asleep, 1'b0);
      u_host.cmd(OP_DEEP_SLEEP, 1'b0, 1'b0);
      u_host.tick(100);
      chk(asleep, 1'b1);
      u_host.cmd(OP_WAKE, 1'b0, 1'b0);
      chk(asleep, 1'b0);
      u_host.cmd(OP_DEEP_SLEEP, 1'b0, 1'b0);
      u_host.tick(100);
      chk(asleep, 1'b1);
      reset_dut();
      chk(asleep, 1'b0);
      chk(blk_lock, 1'b1);
      $display("deep sleep test done");
   endtask : t_sleep
   task automatic t_otp();
      quad_mode <= 1'b1;
      u_host.cmd(OP_ENTER_OTP, 1'b1, 1'b0);
      quad_mode <= 1'b0;
      chk(otp_sel, 1'b1);
      u_host.cmd(OP_WRITE_ENABLE_CMD, 1'b0, 1'b0);
      u_host.cmd(OP_WRITE_SEC, 1'b0, 1'b0);
      chk(sec[SEC_OTP_LOCK], 1'b0);
      u_host.cmd(OP_EXIT_OTP, 1'b0, 1'b0);
      chk(otp_sel, 1'b0);
      u_host.cmd(OP_WRITE_ENABLE_CMD, 1'b0, 1'b0);
      u_host.cmd(OP_WRITE_SEC, 1'b0, 1'b1);
      chk(sec[SEC_OTP_LOCK], 1'b0);
      u_host.cmd(OP_WRITE_SEC, 1'b0, 1'b0);
      chk(sec, 8'h03);
      u_host.cmd(OP_ENTER_OTP, 1'b0, 1'b1);
      chk(otp_sel, 1'b0);
      u_host.cmd(OP_ENTER_OTP, 1'b0, 1'b0);
      u_host.cmd(OP_WRITE_ENABLE_CMD, 1'b0, 1'b0);
      qprog(24'h000010, 1'b0);
      wait_wip();
      chk(wq.size(), 0);
      u_host.cmd(OP_EXIT_OTP, 1'b0, 1'b0);
      $display("OTP test done");
   endtask : t_otp
   task automatic t_prot();
      quad_mode <= 1'b1;
      u_host.cmd(OP_WRITE_ENABLE_CMD, 1'b1, 1'b0);
      qprog(24'h000400, 1'b1);
      wait_wip();
      chk(wq.size(), 0);
      quad_mode <= 1'b0;
      u_host.cmd(OP_WRITE_ENABLE_CMD, 1'b0, 1'b0);
      u_host.cmd(OP_PROT_SELECT, 1'b0, 1'b0);
      chk(sec[SEC_PROT_SEL], 1'b1);
      u_host.cmd(OP_WRITE_ENABLE_CMD, 1'b0, 1'b0);
      qprog(24'h000400, 1'b0);
      wait_wip();
      chk(wq.size(), 0);
      pulse(7'h40);
      range_prot <= 1'b1;
      u_host.cmd(OP_WRITE_ENABLE_CMD, 1'b0, 1'b0);
      qprog(24'h000400, 1'b0);
      wait_wip();
      chk(wq.size(), 2);
      range_prot <= 1'b0;
      fact_strap <= 1'b0;
      u_host.tick(4);
      chk(sec[SEC_FACT_LOCK], 1'b0);
      $display("protection select test done");
   endtask : t_prot
   initial begin
      {rst, quad_mode, quad_en, erase_fail, ev, range_prot} = '0;
      fact_strap = 1'b1;
      rst = 1'b1;
      bad_count = 0;
      checked = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      u_host.tick(4);
      t_flags();
      t_qprog();
      t_sleep();
      t_otp();
      t_prot();
      stop_test();
   end
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      $display("Error at %0t: watchdog expired", $time);
      stop_test();
   end
endmodule : test_flash_otp_protect_power_cmds
`default_nettype wire
